/* include/gyo_pkg.sv */
package gyo_pkg;
    // Register byte addresses, one high/low pair per axis, index 0 = X
    localparam logic [2:0][7:0] GYO_HIGH_ADDR = {8'h17, 8'h15, 8'h13};
    localparam logic [2:0][7:0] GYO_LOW_ADDR = {8'h18, 8'h16, 8'h14};
    localparam logic [7:0] GYO_DIVIDER_ADDR = 8'h19;
    // Value after reset of every register in this bank
    localparam logic [7:0] GYO_REG_RESET = 8'h00;
    // Rate that the divider acts upon, in Hz
    localparam int unsigned GYO_INTERNAL_RATE_HZ = 1000;
    // Divider in effect only for this bypass code and lowpass settings strictly between the limits
    localparam logic [1:0] GYO_BYPASS_OFF = 2'h0;
    localparam logic [2:0] GYO_LPF_LOW_LIMIT = 3'h0;
    localparam logic [2:0] GYO_LPF_HIGH_LIMIT = 3'h7;
    // Saturation limits of the corrected sample
    localparam logic [15:0] GYO_POS_LIMIT = 16'h7FFF;
    localparam logic [15:0] GYO_NEG_LIMIT = 16'h8000;
    localparam int GYO_AXES = 3;

    // Three axis samples, two's complement, index 0 = X
    typedef struct packed {
        logic [2:0][15:0] axis;
    } gyo_axes_s;

    // Register access from the serial interface decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gyo_reg_req_s;

    // Whole state of the bank
    typedef struct packed {
        logic [2:0][7:0] bias_high;
        logic [2:0][7:0] bias_low;
        logic [7:0] divider;
        logic [7:0] count;
        gyo_axes_s out;
        logic update;
        logic [7:0] rdata;
    } gyo_state_s;
endpackage

/* src/gyo_offset_rate.sv */
// Notes on behaviour
// - High byte register holds offset bits 15..8.
// - Low byte register holds offset bits 7..0.
// - Signed offset added to raw sample before output.
// - Output rate is internal rate over divider+1.
// - Divider acts on the 1 kHz internal rate.
// - Divider only with bypass 00, lowpass 1..6.
// - Divided strobe updates outputs and feeds FIFO.
// - Bypass field is config bits 1..0, nonzero bypasses.
module gyo_offset_rate #(
    parameter int DIV_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register access
    input wire gyo_pkg::gyo_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    // Filter configuration fields
    input wire logic [1:0] filter_bypass_select,
    input wire logic [2:0] lowpass_filter_setting,
    // Raw samples from the filter
    input wire logic raw_valid,
    input wire gyo_pkg::gyo_axes_s raw_axes,
    // Corrected output registers and their update strobe
    output gyo_pkg::gyo_axes_s out_axes,
    output logic out_update
);
    import gyo_pkg::*;

    // A divider wider than the register byte has no storage behind it
    if (DIV_W < 1 || DIV_W > 8) begin : g_bad_div_w
        $error("DIV_W must lie between 1 and 8");
    end

    gyo_state_s s_ff;
    gyo_state_s nxt_s;
    logic div_effective;
    logic [15:0] corrected [GYO_AXES];

    ////////////////////////////////////////////////////////////////////////
    // bypass field decode
    assign div_effective = (filter_bypass_select == GYO_BYPASS_OFF)
        && (lowpass_filter_setting > GYO_LPF_LOW_LIMIT)
        && (lowpass_filter_setting < GYO_LPF_HIGH_LIMIT);

    ////////////////////////////////////////////////////////////////////////
    // Per-axis corrected sample, taken into the state only on an update
    for (genvar g = 0; g < GYO_AXES; g++) begin : g_axis
        // Sign-extended to 17 bits, so an overflow shows as bits 16 and 15 differing
        logic [16:0] wide_sum;
        assign wide_sum = {raw_axes.axis[g][15], raw_axes.axis[g]}
            + {s_ff.bias_high[g][7], s_ff.bias_high[g], s_ff.bias_low[g]};
        // saturated signed add
        // Clamping keeps a large bias from flipping the sign of the rate
        assign corrected[g] = (wide_sum[16] == wide_sum[15]) ? wide_sum[15:0]
            : (wide_sum[16] ? GYO_NEG_LIMIT : GYO_POS_LIMIT);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: register writes, reads and the sample path
    always_comb begin
        logic [7:0] rd;
        rd = GYO_REG_RESET;
        nxt_s = s_ff;
        nxt_s.update = 1'b0;
        for (int i = 0; i < GYO_AXES; i++) begin
            if (reg_req.wr && reg_req.addr == GYO_HIGH_ADDR[i]) begin
                nxt_s.bias_high[i] = reg_req.wdata;
            end
            if (reg_req.wr && reg_req.addr == GYO_LOW_ADDR[i]) begin
                nxt_s.bias_low[i] = reg_req.wdata;
            end
            if (reg_req.addr == GYO_HIGH_ADDR[i]) begin
                rd = s_ff.bias_high[i];
            end
            if (reg_req.addr == GYO_LOW_ADDR[i]) begin
                rd = s_ff.bias_low[i];
            end
        end
        // Upper bits above DIV_W are dropped, so reads show what is served
        if (reg_req.wr && reg_req.addr == GYO_DIVIDER_ADDR) begin
            nxt_s.divider = reg_req.wdata & 8'((9'h100 >> (8 - DIV_W)) - 9'h001);
        end
        if (reg_req.addr == GYO_DIVIDER_ADDR) begin
            rd = s_ff.divider;
        end
        // Unmapped addresses read as zero
        if (reg_req.rd) begin
            nxt_s.rdata = rd;
        end
        // each raw strobe is one 1 kHz internal period when the divider counts
        if (raw_valid) begin
            // emit on every (divider+1)th internal sample
            // count reloads only at a period end, so new divider waits
            if (!div_effective || s_ff.count == 8'h00) begin
                // one strobe for outputs and FIFO write
                nxt_s.update = 1'b1;
                nxt_s.count = div_effective ? s_ff.divider : 8'h00;
                for (int i = 0; i < GYO_AXES; i++) begin
                    nxt_s.out.axis[i] = corrected[i];
                end
            end else begin
                nxt_s.count = s_ff.count - 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from flops
    assign reg_rdata = s_ff.rdata;
    assign out_axes = s_ff.out;
    assign out_update = s_ff.update;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_period_end;
        raw_valid && div_effective && s_ff.count == 8'h00;
    endsequence

    sequence s_period_mid;
        raw_valid && div_effective && s_ff.count != 8'h00;
    endsequence

    a_high_write: assert property (reg_req.wr && reg_req.addr == GYO_HIGH_ADDR[0]
        |=> s_ff.bias_high[0] == $past(reg_req.wdata)) else $error("x high byte not stored");
    a_low_write: assert property (reg_req.wr && reg_req.addr == GYO_LOW_ADDR[2]
        |=> s_ff.bias_low[2] == $past(reg_req.wdata)) else $error("z low byte not stored");

    // raw plus offset
    // Small operands only, so that saturation cannot hide a wrong sum
    a_offset_add: assert property (raw_valid && !div_effective && raw_axes.axis[0][15:14] == 2'h0
        && s_ff.bias_high[0][7:6] == 2'h0
        |=> out_axes.axis[0] == 16'($past(raw_axes.axis[0]) + {$past(s_ff.bias_high[0]), $past(s_ff.bias_low[0])}))
        else $error("x output is not raw plus offset");

    a_period_reload: assert property (s_period_end
        |=> out_update && s_ff.count == $past(s_ff.divider))
        else $error("period end missed or count not reloaded");
    a_period_count: assert property (s_period_mid
        |=> !out_update && s_ff.count == $past(s_ff.count) - 8'h01)
        else $error("count did not step down");

    a_bypass_every: assert property (raw_valid && !div_effective |=> out_update)
        else $error("divider acted while not in effect");
    a_update_cause: assert property (out_update |-> $past(raw_valid))
        else $error("update without a raw sample");

    // bypass clears the count
    // Checks the outcome rather than the decode, which would hold by construction
    a_bypass_field: assert property (raw_valid && filter_bypass_select != GYO_BYPASS_OFF
        |=> out_update && s_ff.count == 8'h00) else $error("nonzero bypass left divider active");
    a_div_readback: assert property (reg_req.rd && !reg_req.wr && reg_req.addr == GYO_DIVIDER_ADDR
        |=> reg_rdata == $past(s_ff.divider)) else $error("divider read back wrong");

    // count moves on strobes
    // The counter must measure internal periods, not clock cycles
    a_count_hold: assert property (!raw_valid |=> $stable(s_ff.count))
        else $error("count moved without an internal sample");

    ////////////////////////////////////////////////////////////////////////
    // Per-axis checks, one copy for each of X, Y and Z
    for (genvar g = 0; g < GYO_AXES; g++) begin : g_axis_chk
        sequence s_high_wr;
            reg_req.wr && reg_req.addr == GYO_HIGH_ADDR[g];
        endsequence

        sequence s_low_wr;
            reg_req.wr && reg_req.addr == GYO_LOW_ADDR[g];
        endsequence

        sequence s_sample_taken;
            raw_valid && !div_effective;
        endsequence

        a_axis_high: assert property (s_high_wr |=> s_ff.bias_high[g] == $past(reg_req.wdata))
            else $error("axis high byte not stored");
        a_axis_low: assert property (s_low_wr |=> s_ff.bias_low[g] == $past(reg_req.wdata))
            else $error("axis low byte not stored");

        a_axis_read_high: assert property (reg_req.rd && reg_req.addr == GYO_HIGH_ADDR[g]
            |=> reg_rdata == $past(s_ff.bias_high[g])) else $error("axis high byte read back wrong");
        a_axis_read_low: assert property (reg_req.rd && reg_req.addr == GYO_LOW_ADDR[g]
            |=> reg_rdata == $past(s_ff.bias_low[g])) else $error("axis low byte read back wrong");

        // outputs hold between updates
        // A reader between updates must see one coherent sample
        a_axis_hold: assert property (!out_update |-> $stable(out_axes.axis[g]))
            else $error("axis output changed without an update");

        // positive clamp
        // Wrapping would turn a large positive rate into a negative one
        a_axis_clamp_pos: assert property (s_sample_taken ##0
            (!raw_axes.axis[g][15] && !s_ff.bias_high[g][7]) |=> !out_axes.axis[g][15])
            else $error("positive sum wrapped negative");
        a_axis_clamp_neg: assert property (s_sample_taken ##0
            (raw_axes.axis[g][15] && s_ff.bias_high[g][7]) |=> out_axes.axis[g][15])
            else $error("negative sum wrapped positive");
    end
endmodule

/* test/gyo_host_model.sv */
// Host side of the register port: one access per call
module gyo_host_model (
    // Clock
    input wire logic clk,
    // Register access
    output gyo_pkg::gyo_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import gyo_pkg::*;
    initial reg_req = '0;
    // Strobe for one edge, then scramble idle fields so stale values never look valid
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] q);
        @(posedge clk);
        #1 reg_req = '{wr, !wr, addr, wdata};
        @(posedge clk);
        #1 reg_req = '{1'b0, 1'b0, ~addr, ~wdata};
        q = reg_rdata;
    endtask
endmodule

/* test/tb_gyro_offset_and_rate_divider.sv */
module tb_gyro_offset_and_rate_divider;
    timeunit 1ns;
    timeprecision 1ps;
    import gyo_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] filter_bypass_select = 2'h1;
    logic [2:0] lowpass_filter_setting = 3'h0;
    logic raw_valid = 1'b0;
    gyo_axes_s raw_axes = '0;
    gyo_axes_s out_axes;
    gyo_reg_req_s reg_req;
    logic [7:0] reg_rdata;
    logic out_update;
    logic [7:0] q;
    int fail_count = 0;
    int comparisons = 0;
    gyo_offset_rate i_dut (.clk(clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .filter_bypass_select(filter_bypass_select), .lowpass_filter_setting(lowpass_filter_setting),
        .raw_valid(raw_valid), .raw_axes(raw_axes), .out_axes(out_axes), .out_update(out_update));
    gyo_host_model i_host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
    // 250 MHz clock
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One raw sample; reports whether the outputs updated
    task automatic sample(output logic upd);
        @(posedge clk);
        #1 raw_valid = 1'b1;
        @(posedge clk);
        #1 raw_valid = 1'b0;
        upd = out_update;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Reset values, read back of all seven, unmapped address reads zero
    task automatic t_regs();
        for (int a = 8'h13; a <= 8'h1A; a++) begin
            i_host.access(1'b0, 8'(a), 8'h00, q);
            check("reset value", 16'(GYO_REG_RESET), 16'(q));
            i_host.access(1'b1, 8'(a), 8'(a + 8'h50), q);
        end
        for (int a = 8'h13; a <= 8'h1A; a++) begin
            i_host.access(1'b0, 8'(a), 8'h00, q);
            check("read back", (a == 8'h1A) ? 16'h0000 : 16'(8'(a + 8'h50)), 16'(q));
        end
        $display("test regs done");
    endtask
    // Signed offsets: positive, minus one, saturating high
    task automatic t_offset();
        logic u;
        logic [7:0] vals[7] = '{8'h01, 8'h10, 8'hFF, 8'hFF, 8'h7F, 8'h00, 8'h00};
        for (int i = 0; i < 7; i++) i_host.access(1'b1, 8'(8'h13 + i), vals[i], q);
        raw_axes.axis = {16'h7FFF, 16'h0000, 16'h0005};
        sample(u);
        check("update", 16'h0001, 16'(u));
        check("x out", 16'h0115, out_axes.axis[0]);
        check("y out", 16'hFFFF, out_axes.axis[1]);
        check("z out", 16'h7FFF, out_axes.axis[2]);
        // Negative raw plus minus one must clamp, not wrap to positive
        raw_axes.axis[1] = 16'h8000;
        sample(u);
        check("y low limit", 16'h8000, out_axes.axis[1]);
        $display("test offset done");
    endtask
    // Divider by 3 across every bypass code and lowpass settings 0, 1, 3, 6 and 7
    task automatic t_divider();
        logic u;
        int n;
        logic [1:0] bp[7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
        logic [2:0] lp[7] = '{3'h0, 3'h7, 3'h3, 3'h3, 3'h3, 3'h1, 3'h6};
        int exp[7] = '{6, 6, 6, 6, 6, 2, 2};
        i_host.access(1'b1, GYO_DIVIDER_ADDR, 8'h02, q);
        for (int c = 0; c < 7; c++) begin
            filter_bypass_select = bp[c];
            lowpass_filter_setting = lp[c];
            n = 0;
            for (int s = 0; s < 6; s++) begin
                sample(u);
                n += int'(u === 1'b1);
            end
            check("update count", 16'(exp[c]), 16'(n));
        end
        $display("test divider done");
    endtask
    // Full 8-bit divide by 256, then a new divider that waits for the running period
    task automatic t_reload();
        logic u;
        int n;
        filter_bypass_select = GYO_BYPASS_OFF;
        lowpass_filter_setting = 3'h2;
        i_host.access(1'b1, GYO_DIVIDER_ADDR, 8'hFF, q);
        n = 0;
        for (int s = 0; s < 257; s++) begin
            sample(u);
            n += int'(u === 1'b1);
        end
        check("divide by 256 count", 16'h0002, 16'(n));
        // One bypassed sample clears the running count
        filter_bypass_select = 2'h1;
        sample(u);
        filter_bypass_select = GYO_BYPASS_OFF;
        i_host.access(1'b1, GYO_DIVIDER_ADDR, 8'h03, q);
        sample(u);
        check("period start update", 16'h0001, 16'(u));
        i_host.access(1'b1, GYO_DIVIDER_ADDR, 8'h00, q);
        n = 0;
        for (int s = 0; s < 6; s++) begin
            sample(u);
            n += int'(u === 1'b1);
        end
        check("updates after rewrite", 16'h0003, 16'(n));
        $display("test reload done");
    endtask
    // Watchdog
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 reset = 1'b0;
        t_regs();
        t_offset();
        t_divider();
        t_reload();
        end_of_test();
    end
endmodule
